//--- common/eeprom_ctl_pkg.sv
// constants, field layout and types for the eeprom program/erase control block
package eeprom_ctl_pkg;
	localparam int AXI_AW = 18;
	localparam int AXI_DW = 32;
	localparam int IDX_W = 16;
	localparam int ADDR_LSB = 2;
	localparam int ARR_AW = 9;
	localparam int BYTE_W = 8;
	// register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] CTRL_IDX = 16'hFE1B;
	localparam logic [IDX_W-1:0] NVB_IDX = 16'hFE1C;
	localparam logic [IDX_W-1:0] SHADOW_IDX = 16'hFE1F;
	localparam logic [IDX_W-1:0] ARRAY_FIRST_IDX = 16'h0800;
	localparam logic [IDX_W-1:0] ARRAY_LAST_IDX = 16'h09FF;
	// nv_program_control fields
	localparam int CB_SPARE = 7;
	localparam int CB_PDOWN = 6;
	localparam int CB_MODE_HI = 5;
	localparam int CB_MODE_LO = 4;
	localparam int CB_LATCH = 3;
	localparam int CB_AUTO = 1;
	localparam int CB_HVEN = 0;
	// array_config_shadow fields
	localparam int SB_SEC = 4;
	localparam int SB_BP_HI = 3;
	localparam int SB_BP_LO = 0;
	// block geometry and secured region (array offsets)
	localparam int BLK_HI = 8;
	localparam int BLK_LO = 7;
	localparam logic [BLK_LO-1:0] BLK_FIRST = 7'h00;
	localparam logic [BLK_LO-1:0] BLK_LAST = 7'h7F;
	localparam logic [ARR_AW-1:0] ARR_FIRST = 9'h000;
	localparam logic [ARR_AW-1:0] ARR_LAST = 9'h1FF;
	localparam logic [ARR_AW-1:0] SEC_REGION_LO = 9'h0F0;
	localparam logic [ARR_AW-1:0] SEC_REGION_HI = 9'h0FF;
	localparam logic [BYTE_W-1:0] ERASED_BYTE = 8'hFF;
	localparam logic [BYTE_W-1:0] NV_FACTORY = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int OP_TIME_NS = 10000;
	localparam int OP_CYCLES = OP_TIME_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		MODE_BYTE_PROG = 2'h0,
		MODE_BYTE_ERASE = 2'h1,
		MODE_BLOCK_ERASE = 2'h2,
		MODE_BULK_ERASE = 2'h3
	} op_mode_e;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h0,
		SEQ_RUN = 2'h1,
		SEQ_APPLY = 2'h3,
		SEQ_DONE = 2'h2
	} seq_state_e;
endpackage : eeprom_ctl_pkg

//--- rtl/eeprom_store.sv
// byte array storage with registered read data
`timescale 1ns/100ps
module eeprom_store #(
	parameter int AW = 9,
	parameter int DW = 8
) (
	input wire logic aclk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : eeprom_store

//--- rtl/eeprom_program_erase_control.sv
// program/erase control for the byte-wide eeprom array with an axi4-lite register slave
// Operation
// - latch only writes that address the array
// - newest captured address and data win
// - latched read returns data, captures read address
// - block and bulk erase spare config byte
// - enable set ignored without latch or target
// - enable starts sequence, freezes mode selection
// - clearing both bits clears only enable
// - latch stays set while enable set
// - wait mode leaves the sequence running
// - stop halts, removes pump, restarts, blocks access
// - stop with both clear aborts sequence
// - power-down bit disables array, reset clears
// - mode field codes; protect bit forbids all
// - self-clear bit lets timer clear enable
// - enable drives charge pump when armed
// - one spare read/write bit, no function
// - read-only shadow loaded from config byte
// - shadow holds security bit and protect bits
// - security active low, needs mask option
// - four 128-byte blocks, bit 0 lowest
// - security guards region, erases, config byte
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps
module eeprom_program_erase_control
	import eeprom_ctl_pkg::*;
#(
	parameter int OP_CYCLES_P = OP_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [AXI_AW-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [AXI_DW-1:0] wdata,
	input wire logic [AXI_DW/8-1:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AXI_AW-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [AXI_DW-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic stop_mode,
	input wire logic security_mask_option,
	output logic charge_pump_on,
	output logic array_powered
);
	localparam int TW = $clog2(OP_CYCLES_P + 1);

	logic spare_bit_r, array_power_down_r, bus_latch_enable_r, auto_clear_r;
	logic high_voltage_enable_r;
	op_mode_e mode_r;
	logic [ARR_AW-1:0] cap_addr_r;
	logic [BYTE_W-1:0] cap_data_r;
	logic cap_nv_r, cap_valid_r;
	logic [BYTE_W-1:0] nv_byte_r, shadow_r;
	logic sec_opt_r;
	seq_state_e state_r;
	logic [TW-1:0] timer_r;
	logic [ARR_AW-1:0] walk_r, walk_end_r;
	logic phase_r, spoil_r, block_r, hv_r;
	logic bvalid_r, rvalid_r, rd_pend_r, rd_mem_r;
	logic [1:0] bresp_r, rresp_r, rresp_nxt;
	logic [BYTE_W-1:0] rd_imm_r, rbyte_r, rd_imm, mem_rd;
	logic rd_from_mem;

	logic [IDX_W-1:0] w_idx, r_idx;
	logic w_arr, w_nv, w_ctrl, w_shadow, r_arr, r_nv, r_ctrl, r_shadow;
	logic wr_fire, ar_fire, ctrl_wr, arr_ok, sec_en, hw_clear, stop_hold;
	logic mem_we, walk_allowed;
	logic [BYTE_W-1:0] ctrl_val, mem_wdata;

	assign w_idx = awaddr[ADDR_LSB +: IDX_W];
	assign r_idx = araddr[ADDR_LSB +: IDX_W];
	assign w_arr = (w_idx >= ARRAY_FIRST_IDX) && (w_idx <= ARRAY_LAST_IDX);
	assign r_arr = (r_idx >= ARRAY_FIRST_IDX) && (r_idx <= ARRAY_LAST_IDX);
	assign w_nv = (w_idx == NVB_IDX);
	assign r_nv = (r_idx == NVB_IDX);
	assign w_ctrl = (w_idx == CTRL_IDX);
	assign r_ctrl = (r_idx == CTRL_IDX);
	assign w_shadow = (w_idx == SHADOW_IDX);
	assign r_shadow = (r_idx == SHADOW_IDX);

	// axi handshakes: write address and data taken together
	assign wr_fire = awvalid && wvalid && !bvalid_r;
	assign awready = wr_fire;
	assign wready = wr_fire;
	assign ar_fire = arvalid && !rvalid_r && !rd_pend_r;
	assign arready = ar_fire;
	assign ctrl_wr = wr_fire && w_ctrl && wstrb[0];
	assign arr_ok = !block_r && !array_power_down_r;
	assign sec_en = sec_opt_r && !shadow_r[SB_SEC];
	assign hw_clear = (state_r == SEQ_DONE) && auto_clear_r;
	assign stop_hold = stop_mode && bus_latch_enable_r && high_voltage_enable_r;
	assign ctrl_val = {spare_bit_r, array_power_down_r, mode_r, bus_latch_enable_r, 1'b0,
		auto_clear_r, high_voltage_enable_r};

	// strap capture, mask option for security
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_opt_r <= 1'b0;
		end else begin
			sec_opt_r <= security_mask_option;
		end
	end

	// control register fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			spare_bit_r <= 1'b0;
			array_power_down_r <= 1'b0;
			auto_clear_r <= 1'b0;
			mode_r <= MODE_BYTE_PROG;
			bus_latch_enable_r <= 1'b0;
		end else if (ctrl_wr) begin
			spare_bit_r <= wdata[CB_SPARE];
			array_power_down_r <= wdata[CB_PDOWN];
			auto_clear_r <= wdata[CB_AUTO];
			if (!high_voltage_enable_r) begin
				mode_r <= op_mode_e'(wdata[CB_MODE_HI:CB_MODE_LO]);
			end
			bus_latch_enable_r <= wdata[CB_LATCH] || high_voltage_enable_r;
		end
	end

	// high voltage enable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			high_voltage_enable_r <= 1'b0;
		end else if (ctrl_wr) begin
			if (!wdata[CB_HVEN]) begin
				high_voltage_enable_r <= 1'b0;
			end else if (bus_latch_enable_r && cap_valid_r) begin
				high_voltage_enable_r <= 1'b1;
			end
		end else if (hw_clear) begin
			high_voltage_enable_r <= 1'b0;
		end
	end

	// captured target address and data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_valid_r <= 1'b0;
			cap_nv_r <= 1'b0;
			cap_addr_r <= ARR_FIRST;
			cap_data_r <= ERASED_BYTE;
		end else if (!bus_latch_enable_r) begin
			cap_valid_r <= 1'b0;
		end else if (wr_fire && (w_arr || w_nv) && wstrb[0] && arr_ok
			&& !high_voltage_enable_r) begin
			cap_valid_r <= 1'b1;
			cap_nv_r <= w_nv;
			cap_addr_r <= w_idx[ARR_AW-1:0];
			cap_data_r <= wdata[BYTE_W-1:0];
		end else if (ar_fire && (r_arr || r_nv) && arr_ok && !high_voltage_enable_r) begin
			cap_valid_r <= 1'b1;
			cap_nv_r <= r_nv;
			cap_addr_r <= r_idx[ARR_AW-1:0];
		end
	end

	// an array read during an enabled cycle spoils that cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			spoil_r <= 1'b0;
		end else if (ar_fire && (r_arr || r_nv) && high_voltage_enable_r) begin
			spoil_r <= 1'b1;
		end else if (state_r == SEQ_IDLE && !high_voltage_enable_r) begin
			spoil_r <= 1'b0;
		end
	end

	// sequencer; processor wait has no input here and never pauses it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= SEQ_IDLE;
			timer_r <= '0;
			walk_r <= ARR_FIRST;
			walk_end_r <= ARR_FIRST;
			phase_r <= 1'b0;
		end else begin
			unique case (state_r)
				SEQ_IDLE: begin
					timer_r <= '0;
					if (high_voltage_enable_r && !stop_mode) begin
						state_r <= SEQ_RUN;
					end
				end
				SEQ_RUN: begin
					if (!high_voltage_enable_r) begin
						state_r <= SEQ_IDLE;
					end else if (stop_hold) begin
						timer_r <= '0;
					end else if (timer_r == TW'(OP_CYCLES_P - 1)) begin
						state_r <= SEQ_APPLY;
						phase_r <= 1'b0;
						unique case (mode_r)
							MODE_BYTE_PROG, MODE_BYTE_ERASE: begin
								walk_r <= cap_addr_r;
								walk_end_r <= cap_addr_r;
							end
							MODE_BLOCK_ERASE: begin
								walk_r <= {cap_addr_r[BLK_HI:BLK_LO], BLK_FIRST};
								walk_end_r <= {cap_addr_r[BLK_HI:BLK_LO], BLK_LAST};
							end
							MODE_BULK_ERASE: begin
								walk_r <= ARR_FIRST;
								walk_end_r <= ARR_LAST;
							end
						endcase
					end else begin
						timer_r <= timer_r + TW'(1);
					end
				end
				SEQ_APPLY: begin
					if (stop_mode && !bus_latch_enable_r && !high_voltage_enable_r) begin
						state_r <= SEQ_IDLE;
					end else if (stop_hold) begin
						state_r <= SEQ_RUN;
						timer_r <= '0;
					end else if (!phase_r) begin
						phase_r <= 1'b1;
					end else begin
						phase_r <= 1'b0;
						if (walk_r == walk_end_r) begin
							state_r <= SEQ_DONE;
						end else begin
							walk_r <= walk_r + ARR_AW'(1);
						end
					end
				end
				SEQ_DONE: begin
					if (!high_voltage_enable_r) begin
						state_r <= SEQ_IDLE;
					end
				end
			endcase
		end
	end

	// access block after a stop that caught an armed sequence
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			block_r <= 1'b0;
		end else if (stop_hold && (state_r == SEQ_RUN || state_r == SEQ_APPLY)) begin
			block_r <= 1'b1;
		end else if (state_r == SEQ_DONE || state_r == SEQ_IDLE) begin
			block_r <= 1'b0;
		end
	end

	// charge pump only while armed, sequencing and not stopped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hv_r <= 1'b0;
		end else begin
			hv_r <= high_voltage_enable_r && !stop_mode
				&& (state_r == SEQ_RUN || state_r == SEQ_APPLY);
		end
	end
	assign charge_pump_on = hv_r;
	assign array_powered = !array_power_down_r;

	// per-address protection during the walk
	always_comb begin
		walk_allowed = !shadow_r[SB_BP_LO + walk_r[BLK_HI:BLK_LO]] && !spoil_r;
		if (sec_en && (walk_r >= SEC_REGION_LO) && (walk_r <= SEC_REGION_HI)) begin
			walk_allowed = 1'b0;
		end
		if (sec_en && (mode_r == MODE_BLOCK_ERASE || mode_r == MODE_BULK_ERASE)) begin
			walk_allowed = 1'b0;
		end
	end
	assign mem_we = (state_r == SEQ_APPLY) && phase_r && !cap_nv_r && walk_allowed && !stop_mode;
	assign mem_wdata = (mode_r == MODE_BYTE_PROG) ? (mem_rd & cap_data_r) : ERASED_BYTE;

	eeprom_store #(
		.AW(ARR_AW),
		.DW(BYTE_W)
	) u_store (
		.aclk(aclk),
		.wr_en(mem_we),
		.wr_addr(walk_r),
		.wr_data(mem_wdata),
		.rd_en((state_r == SEQ_APPLY) || (ar_fire && rd_from_mem)),
		.rd_addr((state_r == SEQ_APPLY) ? walk_r : r_idx[ARR_AW-1:0]),
		.rd_data(mem_rd)
	);

	// config byte and its read-only shadow
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nv_byte_r <= NV_FACTORY;
		end else if ((state_r == SEQ_APPLY) && phase_r && cap_nv_r && !spoil_r && !sec_en
			&& !stop_mode && (mode_r == MODE_BYTE_PROG || mode_r == MODE_BYTE_ERASE)) begin
			nv_byte_r <= (mode_r == MODE_BYTE_PROG) ? (nv_byte_r & cap_data_r)
				: ERASED_BYTE;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shadow_r <= NV_FACTORY;
		end else if (ar_fire && r_nv && arr_ok && !bus_latch_enable_r) begin
			shadow_r <= nv_byte_r;
		end
	end

	// read data selection
	always_comb begin
		rd_imm = '0;
		rresp_nxt = RESP_OKAY;
		rd_from_mem = 1'b0;
		if (r_ctrl) begin
			rd_imm = ctrl_val;
		end else if (r_shadow) begin
			rd_imm = shadow_r;
		end else if (r_arr || r_nv) begin
			if (block_r) begin
				rresp_nxt = RESP_SLVERR;
			end else if (array_power_down_r) begin
				rd_imm = '0;
			end else if (bus_latch_enable_r) begin
				rd_imm = cap_data_r;
			end else if (r_nv) begin
				rd_imm = nv_byte_r;
			end else begin
				rd_from_mem = 1'b1;
			end
		end else begin
			rresp_nxt = RESP_SLVERR;
		end
	end

	// read channel: answer two cycles after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_pend_r <= 1'b0;
			rd_mem_r <= 1'b0;
			rd_imm_r <= '0;
			rvalid_r <= 1'b0;
			rresp_r <= RESP_OKAY;
			rbyte_r <= '0;
		end else begin
			rd_pend_r <= ar_fire;
			if (ar_fire) begin
				rd_mem_r <= rd_from_mem;
				rd_imm_r <= rd_imm;
				rresp_r <= rresp_nxt;
			end
			if (rd_pend_r) begin
				rvalid_r <= 1'b1;
				rbyte_r <= rd_mem_r ? mem_rd : rd_imm_r;
			end else if (rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end
	assign rvalid = rvalid_r;
	assign rresp = rresp_r;
	assign rdata = {{(AXI_DW-BYTE_W){1'b0}}, rbyte_r};

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			if (!(w_arr || w_nv || w_ctrl || w_shadow) || ((w_arr || w_nv) && block_r)) begin
				bresp_r <= RESP_SLVERR;
			end else begin
				bresp_r <= RESP_OKAY;
			end
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	chk_pgm_needs_latch: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(high_voltage_enable_r) |-> $past(bus_latch_enable_r) && $past(cap_valid_r))
		else $error("enable set without latch or target");
	chk_latch_held: assert property (@(posedge aclk) disable iff (!aresetn)
		high_voltage_enable_r |-> bus_latch_enable_r)
		else $error("latch cleared while enable set");
	chk_both_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_wr && high_voltage_enable_r && !wdata[CB_HVEN] && !wdata[CB_LATCH]
		|=> !high_voltage_enable_r && bus_latch_enable_r)
		else $error("double clear did not keep latch");
	chk_mode_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
		high_voltage_enable_r && $past(high_voltage_enable_r) |-> $stable(mode_r))
		else $error("mode changed while enabled");
	chk_auto_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		hw_clear && !ctrl_wr |=> !high_voltage_enable_r)
		else $error("self-clear missed");
	chk_pump_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_mode |=> !charge_pump_on)
		else $error("pump on during stop");
	chk_stop_abort: assert property (@(posedge aclk) disable iff (!aresetn)
		stop_mode && !bus_latch_enable_r && !high_voltage_enable_r && state_r != SEQ_IDLE
		|=> state_r == SEQ_IDLE)
		else $error("sequence not aborted in stop");
	chk_cap_outside: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && !(w_arr || w_nv) && !ar_fire && bus_latch_enable_r
		|=> $stable(cap_addr_r) && $stable(cap_data_r))
		else $error("capture from outside array");
	chk_read_capture: assert property (@(posedge aclk) disable iff (!aresetn)
		ar_fire && r_arr && arr_ok && bus_latch_enable_r && !high_voltage_enable_r
		|=> cap_addr_r == $past(r_idx[ARR_AW-1:0]) ##1 rdata[BYTE_W-1:0] == cap_data_r)
		else $error("latched read mismatch");
	chk_nv_bulk: assert property (@(posedge aclk) disable iff (!aresetn)
		state_r == SEQ_APPLY && (mode_r == MODE_BLOCK_ERASE || mode_r == MODE_BULK_ERASE)
		|=> $stable(nv_byte_r))
		else $error("config byte altered by block erase");
	chk_protect_write: assert property (@(posedge aclk) disable iff (!aresetn)
		mem_we |-> !shadow_r[SB_BP_LO + walk_r[BLK_HI:BLK_LO]])
		else $error("write into protected block");
endmodule : eeprom_program_erase_control

//--- tb/tb_top.sv
// register-level testbench for the eeprom program/erase control block
`timescale 1ns/100ps
module tb_top;
	import eeprom_ctl_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [AXI_AW-1:0] awaddr = '0;
	logic awvalid = 1'b0;
	logic awready;
	logic [AXI_DW-1:0] wdata = '0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b0;
	logic [AXI_AW-1:0] araddr = '0;
	logic arvalid = 1'b0;
	logic arready;
	logic [AXI_DW-1:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b0;
	logic stop_mode = 1'b0;
	logic security_mask_option = 1'b0;
	logic charge_pump_on;
	logic array_powered;
	int fail_count = 0;
	int n_tests = 0;
	logic [7:0] d;
	logic [1:0] r;

	always #2.5 aclk = ~aclk;

	eeprom_program_erase_control #(.OP_CYCLES_P(8)) uut (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.stop_mode(stop_mode), .security_mask_option(security_mask_option),
		.charge_pump_on(charge_pump_on), .array_powered(array_powered)
	);

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : chk

	task automatic hang(input string name);
		$display("CHECK FAILED %s expected completion seen timeout", name);
		fail_count++;
		print_verdict();
	endtask : hang

	task automatic wr(input logic [15:0] idx, input logic [7:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h00_0000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awready && wready) begin
				awvalid <= 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) break;
		end
		rs = bresp;
		bready <= 1'b0;
		if (n == 100) hang("write");
	endtask : wr

	task automatic rd(input logic [15:0] idx, output logic [7:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		v = rdata[7:0];
		rs = rresp;
		rready <= 1'b0;
		if (n == 100) hang("read");
	endtask : rd

	task automatic rchk(input logic [15:0] idx, input logic [7:0] exp, input string name);
		logic [7:0] v;
		logic [1:0] rs;
		rd(idx, v, rs);
		chk(name, {22'h0, rs, v}, {22'h0, RESP_OKAY, exp});
	endtask : rchk

	task automatic poll_hv;
		int k;
		logic [7:0] v;
		logic [1:0] rs;
		for (k = 0; k < 2000; k++) begin
			rd(CTRL_IDX, v, rs);
			if (v[CB_HVEN] === 1'b0) break;
		end
		if (k == 2000) hang("enable self-clear");
	endtask : poll_hv

	task automatic do_op(input logic [1:0] m, input logic [15:0] idx, input logic [7:0] v);
		logic [1:0] rs;
		wr(CTRL_IDX, {2'b00, m, 4'b1010}, rs);
		wr(idx, v, rs);
		chk("op write resp", {30'h0, rs}, {30'h0, RESP_OKAY});
		wr(CTRL_IDX, {2'b00, m, 4'b1011}, rs);
		poll_hv();
		wr(CTRL_IDX, 8'h00, rs);
	endtask : do_op

	task automatic wait_pump(input logic val);
		int n;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (charge_pump_on === val) break;
		end
		chk("charge_pump_on", {31'h0, charge_pump_on}, {31'h0, val});
	endtask : wait_pump

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(CTRL_IDX, 8'h00, "ctrl reset");
		rchk(SHADOW_IDX, NV_FACTORY, "shadow reset");
		chk("powered", {31'h0, array_powered}, 32'h0000_0001);
		wr(CTRL_IDX, 8'h80, r);
		rchk(CTRL_IDX, 8'h80, "spare");
		rd(16'h0123, d, r);
		chk("unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(SHADOW_IDX, 8'h00, r);
		chk("shadow wr resp", {30'h0, r}, {30'h0, RESP_OKAY});
		rchk(SHADOW_IDX, NV_FACTORY, "shadow ro");
		wr(CTRL_IDX, 8'h01, r);
		rchk(CTRL_IDX, 8'h00, "hv no latch");
		wr(CTRL_IDX, 8'h08, r);
		wr(SHADOW_IDX, 8'h00, r);
		wr(CTRL_IDX, 8'h09, r);
		rchk(CTRL_IDX, 8'h08, "hv no target");
		wr(CTRL_IDX, 8'h00, r);
		do_op(2'h3, 16'h0800, 8'h00);
		rchk(16'h0800, ERASED_BYTE, "bulk lo");
		rchk(16'h09FF, ERASED_BYTE, "bulk hi");
		rchk(NVB_IDX, NV_FACTORY, "nv after bulk");
		wr(16'h0830, 8'h00, r);
		rchk(16'h0830, ERASED_BYTE, "unlatched write");
		wr(CTRL_IDX, 8'h0A, r);
		wr(16'h0805, 8'hAA, r);
		wr(16'h0810, 8'h55, r);
		rchk(16'h0805, 8'h55, "latched read");
		wr(CTRL_IDX, 8'h0B, r);
		poll_hv();
		wr(CTRL_IDX, 8'h00, r);
		rchk(16'h0805, 8'h55, "read target");
		rchk(16'h0810, ERASED_BYTE, "replaced target");
		wr(CTRL_IDX, 8'h08, r);
		wr(16'h0820, 8'h0F, r);
		wr(CTRL_IDX, 8'h09, r);
		wr(CTRL_IDX, 8'h01, r);
		rchk(CTRL_IDX, 8'h09, "latch held");
		wr(CTRL_IDX, 8'h00, r);
		rchk(CTRL_IDX, 8'h08, "clear both");
		wr(CTRL_IDX, 8'h00, r);
		rchk(CTRL_IDX, 8'h00, "latch clear");
		wr(CTRL_IDX, 8'h3A, r);
		wr(16'h0800, 8'h00, r);
		wr(CTRL_IDX, 8'h3B, r);
		wait_pump(1'b1);
		wr(CTRL_IDX, 8'h0B, r);
		rchk(CTRL_IDX, 8'h3B, "mode frozen");
		stop_mode <= 1'b1; // stop inside a sequence on purpose
		repeat (4) @(posedge aclk);
		chk("pump in stop", {31'h0, charge_pump_on}, 32'h0);
		stop_mode <= 1'b0;
		rd(NVB_IDX, d, r);
		chk("blocked access", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(16'h0880, 8'h00, r);
		chk("blocked write", {30'h0, r}, {30'h0, RESP_SLVERR});
		poll_hv();
		chk("pump off", {31'h0, charge_pump_on}, 32'h0);
		wr(CTRL_IDX, 8'h00, r);
		do_op(2'h0, 16'h09FF, 8'h00);
		wr(CTRL_IDX, 8'h38, r);
		wr(16'h0800, 8'h00, r);
		wr(CTRL_IDX, 8'h39, r);
		repeat (16) @(posedge aclk);
		wr(CTRL_IDX, 8'h30, r);
		wr(CTRL_IDX, 8'h30, r);
		stop_mode <= 1'b1; // stop inside a sequence on purpose
		repeat (2) @(posedge aclk);
		stop_mode <= 1'b0;
		rchk(16'h09FF, 8'h00, "stop abort");
		do_op(2'h3, 16'h0800, 8'h00);
		do_op(2'h1, NVB_IDX, 8'h00);
		do_op(2'h0, NVB_IDX, 8'h11);
		rchk(NVB_IDX, 8'h11, "nv program");
		rchk(SHADOW_IDX, 8'h11, "shadow load");
		do_op(2'h0, 16'h0800, 8'h00);
		rchk(16'h0800, ERASED_BYTE, "block0 protected");
		do_op(2'h0, 16'h0880, 8'h12);
		rchk(16'h0880, 8'h12, "block1 open");
		do_op(2'h0, 16'h0900, 8'h77);
		do_op(2'h2, 16'h0910, 8'h00);
		rchk(16'h0900, ERASED_BYTE, "block erase");
		rchk(16'h0880, 8'h12, "other block kept");
		do_op(2'h0, NVB_IDX, 8'h01);
		rchk(NVB_IDX, 8'h01, "nv secure");
		do_op(2'h0, 16'h08F1, 8'h56);
		rchk(16'h08F1, 8'h56, "no mask option");
		security_mask_option <= 1'b1;
		do_op(2'h0, 16'h08F0, 8'h00);
		rchk(16'h08F0, ERASED_BYTE, "secured region");
		do_op(2'h3, 16'h0880, 8'h00);
		rchk(16'h0880, 8'h12, "bulk disabled");
		do_op(2'h0, NVB_IDX, 8'h00);
		rchk(NVB_IDX, 8'h01, "nv locked");
		do_op(2'h0, 16'h08EF, 8'h34);
		rchk(16'h08EF, 8'h34, "outside region");
		wr(CTRL_IDX, 8'h40, r);
		chk("powered down", {31'h0, array_powered}, 32'h0);
		rd(16'h0880, d, r);
		chk("off read", {24'h0, d}, 32'h0);
		wr(CTRL_IDX, 8'h00, r);
		chk("powered up", {31'h0, array_powered}, 32'h0000_0001);
		print_verdict();
	end
endmodule : tb_top
